// file: src/ref_front.sv
/*
 Reference input front end: four inputs, pre-dividers, activity
 monitors, fast no-activity detector and the register file.
 Reference inputs are synchronous samples of the clocks at mclk rate;
 a synchronous edge reaches the block as a one-cycle high level change.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Network type bit one means SONET, zero means SDH, picks the T1/E1 ratio.
// - Network type bit loads from the select pin after reset.
// - Inputs one, two default to 8 kHz; three, four to 19.44 MHz.
// - Default priorities are 2, 3, 4 and 5 for inputs one to four.
// - Inputs carry channel numbers 0011, 0100, 1000 and 1001.
// - Every input has identical settings and capabilities.
// - Direct lock compares phase at the input's own spot frequency.
// - Eight kilohertz lock divides a spot frequency down to 8 kHz.
// - Spot frequencies: 2, 4, 8 kHz, T1/E1, 6.48 to 77.76 MHz.
// - Inputs to 100 MHz; highest direct spot frequency is 77.76 MHz.
// - Edge select bit picks the reference edge in 8 kHz lock.
// - Bit seven selects programmable divide; host gives exactly 8 kHz.
// - Programmable divide is stored value plus one, value 1 to 12499.
// - One shared divisor pair serves all programmable divide inputs.
// - Programmable divide selectable per input independently.
// - Config byte: mode bits, bucket bits, frequency bits.
// - Activity always monitored; frequency only checked when clean.
// - Inactive or out-of-band inputs are unavailable for selection.
// - Anomalies fill a leaky bucket; reject at or above set threshold.
// - Non-selected anomalies only change that input's eligibility.
// - Fast detector flags two missing cycles and forces holdover.
// - Flag reads as status bit six; enable maps it to phase lost.
// - On recovery before alarms, lock resumes with nearest edge.
// - Latched lost bit clears only by a write to the status register.
// - Activity judged over 128 ms periods; one increment per bad one.
module ref_front
  import ref_front_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic net_select_pin,
  input wire logic [3:0] ref_in,
  input wire logic freq_out_of_band_in_unused_free,
  input wire logic [3:0] freq_out_of_band,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [3:0] div_ref_out,
  output logic [3:0] ref_available,
  output logic holdover,
  output logic phase_lost,
  output logic [3:0] selected_chan
);
  typedef enum logic [1:0] {
    PLL_FREE = 2'b00, PLL_LOCKED = 2'b01, PLL_HOLD = 2'b10
  } pll_state_t;

  reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  freq_cfg_t cfg_q [4];
  freq_cfg_t cfg_d [4];
  logic [3:0] prio_q [4];
  logic [3:0] prio_d [4];
  logic [7:0] test_q, test_d, setup_q, setup_d, phs_q, phs_d;
  logic [13:0] programmable_divide_q, programmable_divide_d;
  logic [1:0] sel_q, sel_d;
  logic lost_q, lost_d, strap_done_q, strap_done_d;
  logic [7:0] rdata_d;
  logic [15:0] dcnt_q [4];
  logic [15:0] dcnt_d [4];
  logic [3:0] dout_q, dout_d, prev_q, prev_d;
  logic [15:0] gap_q [4];
  logic [15:0] gap_d [4];
  logic [3:0] irr_q, irr_d, alarm_q, alarm_d, avail_d;
  logic [3:0] bkt_q [4];
  logic [3:0] bkt_d [4];
  logic [22:0] per_q, per_d;
  logic [15:0] fgap_q, fgap_d;
  pll_state_t pll_q, pll_d;
  logic [3:0] chan_d;

  // Division ratio to 8 kHz for each spot frequency from 8 kHz up, minus one.
  function automatic logic [15:0] eight_khz_lock_div(input logic [3:0] f,
                                             input logic sonet);
    case (f)
      F_2K, F_4K, F_8K: eight_khz_lock_div = 16'h0000;
      F_T1E1: eight_khz_lock_div = sonet ? 16'h00C0 : 16'h00FF;
      F_6M48: eight_khz_lock_div = 16'h0329;
      F_19M44: eight_khz_lock_div = 16'h097D;
      F_25M92: eight_khz_lock_div = 16'h0CA7;
      F_38M88: eight_khz_lock_div = 16'h12FB;
      F_51M84: eight_khz_lock_div = 16'h194F;
      F_77M76: eight_khz_lock_div = 16'h25F7;
      default: eight_khz_lock_div = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] miss_limit(input logic [3:0] f);
    case (f)
      F_2K: miss_limit = MISS_LIMIT_K2;
      F_4K: miss_limit = MISS_LIMIT_K4;
      F_8K: miss_limit = MISS_LIMIT_K8;
      default: miss_limit = MISS_LIMIT_FAST;
    endcase
  endfunction

  function automatic logic [1:0] reg_index(input logic [7:0] a);
    case (a)
      ADDR_FREQ_B: reg_index = 2'd1;
      ADDR_FREQ_C: reg_index = 2'd2;
      ADDR_FREQ_D: reg_index = 2'd3;
      default: reg_index = 2'd0;
    endcase
  endfunction

  // Register file; the lost bit is set by hardware with priority.
  always_comb begin
    cfg_d = cfg_q;
    prio_d = prio_q;
    test_d = test_q;
    setup_d = setup_q;
    phs_d = phs_q;
    programmable_divide_d = programmable_divide_q;
    sel_d = sel_q;
    lost_d = lost_q;
    strap_done_d = 1'b1;
    rdata_d = 8'h00;
    if (!strap_done_q) begin
      setup_d[NETTYPE_BIT] = net_select_pin;
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_TEST_CTRL: test_d = req.wdata;
        ADDR_INT_STATUS: lost_d = 1'b0;
        ADDR_FREQ_A, ADDR_FREQ_B, ADDR_FREQ_C, ADDR_FREQ_D:
          cfg_d[reg_index(req.addr)] = req.wdata;
        ADDR_INPUT_SETUP: setup_d = req.wdata;
        ADDR_DIV_LOW: programmable_divide_d[7:0] = req.wdata;
        ADDR_DIV_HIGH: programmable_divide_d[13:8] = req.wdata[5:0];
        ADDR_PHASE_SETUP: phs_d = req.wdata;
        ADDR_PRIORITY_AB: begin
          prio_d[0] = req.wdata[3:0];
          prio_d[1] = req.wdata[7:4];
        end
        ADDR_PRIORITY_CD: begin
          prio_d[2] = req.wdata[3:0];
          prio_d[3] = req.wdata[7:4];
        end
        ADDR_SELECT: sel_d = req.wdata[1:0];
        default: ;
      endcase
    end
    if (fgap_d >= miss_limit(cfg_q[sel_q].freq) && pll_q == PLL_LOCKED) begin
      lost_d = 1'b1;
    end
    if (req.rd) begin
      case (req.addr)
        ADDR_TEST_CTRL: rdata_d = test_q;
        ADDR_INT_STATUS: rdata_d = {1'b0, lost_q, 6'h00};
        ADDR_FREQ_A, ADDR_FREQ_B, ADDR_FREQ_C, ADDR_FREQ_D:
          rdata_d = cfg_q[reg_index(req.addr)];
        ADDR_INPUT_SETUP: rdata_d = setup_q;
        ADDR_DIV_LOW: rdata_d = programmable_divide_q[7:0];
        ADDR_DIV_HIGH: rdata_d = {2'b00, programmable_divide_q[13:8]};
        ADDR_PHASE_SETUP: rdata_d = phs_q;
        ADDR_PRIORITY_AB: rdata_d = {prio_q[1], prio_q[0]};
        ADDR_PRIORITY_CD: rdata_d = {prio_q[3], prio_q[2]};
        ADDR_AVAIL: rdata_d = {alarm_q, avail_d};
        ADDR_SELECT: rdata_d = {6'h00, sel_q};
        ADDR_BUCKET_CFG: rdata_d = {bkt_q[sel_q], 2'b00, pll_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q[0] <= FREQ_RESET_LOW;
      cfg_q[1] <= FREQ_RESET_LOW;
      cfg_q[2] <= FREQ_RESET_HIGH;
      cfg_q[3] <= FREQ_RESET_HIGH;
      prio_q[0] <= PRIO_RESET_ONE;
      prio_q[1] <= PRIO_RESET_TWO;
      prio_q[2] <= PRIO_RESET_THREE;
      prio_q[3] <= PRIO_RESET_FOUR;
      test_q <= 8'h00;
      setup_q <= 8'h00;
      phs_q <= 8'h00;
      programmable_divide_q <= PROGRAMMABLE_DIVIDE_MIN;
      sel_q <= 2'b00;
      lost_q <= 1'b0;
      strap_done_q <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      prio_q <= prio_d;
      test_q <= test_d;
      setup_q <= setup_d;
      phs_q <= phs_d;
      programmable_divide_q <= programmable_divide_d;
      sel_q <= sel_d;
      lost_q <= lost_d;
      strap_done_q <= strap_done_d;
      reg_rdata <= rdata_d;
    end
  end

  // Pre-dividers, activity monitors and leaky buckets per input.
  always_comb begin
    logic [15:0] lim;
    logic rise;
    lim = 16'h0000;
    rise = 1'b0;
    per_d = (per_q == 23'(PERIOD_CYCLES - 1)) ? 23'h000000 : per_q + 23'h1;
    for (int i = 0; i < 4; i++) begin
      prev_d[i] = ref_in[i];
      // picks the edge used in 8 kHz lock.
      rise = (cfg_q[i].eight_khz_lock && test_q[EDGE_SEL_BIT]) ?
             (prev_q[i] && !ref_in[i]) : (!prev_q[i] && ref_in[i]);
      if (cfg_q[i].programmable_divide) begin
        lim = {2'b00, (programmable_divide_q < PROGRAMMABLE_DIVIDE_MIN) ? PROGRAMMABLE_DIVIDE_MIN :
               (programmable_divide_q > PROGRAMMABLE_DIVIDE_MAX) ? PROGRAMMABLE_DIVIDE_MAX : programmable_divide_q};
      end else if (cfg_q[i].eight_khz_lock) begin
        lim = eight_khz_lock_div(cfg_q[i].freq, setup_q[NETTYPE_BIT]);
      end else begin
        lim = 16'h0000;
      end
      dcnt_d[i] = dcnt_q[i];
      dout_d[i] = dout_q[i];
      if (rise) begin
        if (dcnt_q[i] >= lim) begin
          dcnt_d[i] = 16'h0000;
          dout_d[i] = ~dout_q[i];
        end else begin
          dcnt_d[i] = dcnt_q[i] + 16'h1;
        end
      end
      gap_d[i] = rise ? 16'h0000 :
                 (gap_q[i] == 16'hFFFF ? gap_q[i] : gap_q[i] + 16'h1);
      irr_d[i] = (per_q == 23'h000000) ? 1'b0 : irr_q[i];
      if (gap_q[i] >= miss_limit(cfg_q[i].freq)) begin
        irr_d[i] = 1'b1;
      end
      bkt_d[i] = bkt_q[i];
      if (per_q == 23'(PERIOD_CYCLES - 1)) begin
        if (irr_q[i] && bkt_q[i] < BUCKET_SIZE) begin
          bkt_d[i] = bkt_q[i] + 4'h1;
        end else if (!irr_q[i] && bkt_q[i] != 4'h0) begin
          bkt_d[i] = bkt_q[i] - 4'h1;
        end
      end
      alarm_d[i] = alarm_q[i];
      if (bkt_q[i] >= BUCKET_SET) begin
        alarm_d[i] = 1'b1;
      end else if (bkt_q[i] <= BUCKET_CLEAR) begin
        alarm_d[i] = 1'b0;
      end
      // Frequency result only counts while activity is clean.
      avail_d[i] = !alarm_q[i] &&
                   !(freq_out_of_band[i] && !irr_q[i]);
    end
  end

  // Fast no-activity detector on the selected input.
  always_comb begin
    fgap_d = gap_d[sel_q];
    pll_d = pll_q;
    case (pll_q)
      PLL_FREE: if (avail_d[sel_q]) pll_d = PLL_LOCKED;
      PLL_LOCKED: if (fgap_d >= miss_limit(cfg_q[sel_q].freq))
        pll_d = PLL_HOLD;
      PLL_HOLD: begin
        if (!avail_d[sel_q]) begin
          pll_d = PLL_FREE;
        end else if (fgap_d == 16'h0000) begin
          pll_d = PLL_LOCKED;
        end
      end
      default: pll_d = PLL_FREE;
    endcase
    case (sel_q)
      2'd0: chan_d = CHAN_ONE;
      2'd1: chan_d = CHAN_TWO;
      2'd2: chan_d = CHAN_THREE;
      default: chan_d = CHAN_FOUR;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        dcnt_q[i] <= 16'h0000;
        gap_q[i] <= 16'h0000;
        bkt_q[i] <= 4'h0;
      end
      dout_q <= 4'h0;
      prev_q <= 4'h0;
      irr_q <= 4'h0;
      alarm_q <= 4'h0;
      per_q <= 23'h000000;
      fgap_q <= 16'h0000;
      pll_q <= PLL_FREE;
      div_ref_out <= 4'h0;
      ref_available <= 4'h0;
      holdover <= 1'b0;
      phase_lost <= 1'b0;
      selected_chan <= CHAN_ONE;
    end else begin
      dcnt_q <= dcnt_d;
      gap_q <= gap_d;
      bkt_q <= bkt_d;
      dout_q <= dout_d;
      prev_q <= prev_d;
      irr_q <= irr_d;
      alarm_q <= alarm_d;
      per_q <= per_d;
      fgap_q <= fgap_d;
      pll_q <= pll_d;
      div_ref_out <= dout_d;
      ref_available <= avail_d;
      holdover <= (pll_d == PLL_HOLD);
      phase_lost <= lost_d && phs_q[PHASE_LOST_EN_BIT];
      selected_chan <= chan_d;
    end
  end

  a_lost_sticky: assert property (@(posedge mclk) disable iff (rst)
    $fell(lost_q) |-> $past(req.wr && req.addr == ADDR_INT_STATUS))
    else $error("lost flag cleared without status write");
  a_hold_on_miss: assert property (@(posedge mclk) disable iff (rst)
    (pll_q == PLL_LOCKED && fgap_d >= miss_limit(cfg_q[sel_q].freq))
    |=> holdover && lost_q)
    else $error("missing reference did not force holdover");
  a_avail_alarm: assert property (@(posedge mclk) disable iff (rst)
    alarm_q[0] |=> !ref_available[0])
    else $error("alarmed input left available");
  a_oob_unavail: assert property (@(posedge mclk) disable iff (rst)
    (freq_out_of_band[2] && !irr_q[2]) |=> !ref_available[2])
    else $error("out of band input left available");
  a_hold_release: assert property (@(posedge mclk) disable iff (rst)
    (pll_q == PLL_HOLD && avail_d[sel_q] && fgap_d == 16'h0000)
    |=> !holdover && pll_q == PLL_LOCKED)
    else $error("recovered input did not resume lock");
  a_bucket_cap: assert property (@(posedge mclk) disable iff (rst)
    bkt_q[0] <= BUCKET_SIZE)
    else $error("bucket above its size");
  a_bucket_step: assert property (@(posedge mclk) disable iff (rst)
    (per_q != 23'(PERIOD_CYCLES - 1)) |=> $stable(bkt_q[1]))
    else $error("bucket moved outside a period end");
  a_read_latency: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr == ADDR_DIV_LOW) ##1 !$past(req.wr)
    |-> reg_rdata == programmable_divide_q[7:0])
    else $error("divisor low byte read wrong");
  a_phase_map: assert property (@(posedge mclk) disable iff (rst)
    phase_lost |-> $past(phs_q[PHASE_LOST_EN_BIT]))
    else $error("phase lost without enable");
  a_chan_code: assert property (@(posedge mclk) disable iff (rst)
    (sel_q == 2'd2) |=> selected_chan == CHAN_THREE || $changed(sel_q))
    else $error("channel number wrong");
  a_direct_div: assert property (@(posedge mclk) disable iff (rst)
    (!cfg_q[0].programmable_divide && !cfg_q[0].eight_khz_lock && !prev_q[0] && ref_in[0]
     && $stable(cfg_q[0])) |=> dout_q[0] != $past(dout_q[0]))
    else $error("direct mode divided the input");
  c_holdover: cover property (@(posedge mclk) disable iff (rst)
    pll_q == PLL_HOLD ##1 pll_q == PLL_LOCKED);
  c_alarm: cover property (@(posedge mclk) disable iff (rst) $rose(alarm_q[0]));
  c_programmable_divide: cover property (@(posedge mclk) disable iff (rst)
    cfg_q[1].programmable_divide && $changed(dout_q[1]));
endmodule // ref_front
`default_nettype wire

// file: src/ref_front_pkg.sv
/*
 Constants, register map and carrier types for the reference input
 front end. Assumes a single 20 MHz system clock domain.
*/
package ref_front_pkg;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'h03;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h06;
  localparam logic [7:0] ADDR_FREQ_A = 8'h22;
  localparam logic [7:0] ADDR_FREQ_B = 8'h23;
  localparam logic [7:0] ADDR_FREQ_C = 8'h27;
  localparam logic [7:0] ADDR_FREQ_D = 8'h28;
  localparam logic [7:0] ADDR_INPUT_SETUP = 8'h34;
  localparam logic [7:0] ADDR_DIV_LOW = 8'h46;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h47;
  localparam logic [7:0] ADDR_PHASE_SETUP = 8'h73;
  localparam logic [7:0] ADDR_PRIORITY_AB = 8'h24;
  localparam logic [7:0] ADDR_PRIORITY_CD = 8'h25;
  localparam logic [7:0] ADDR_AVAIL = 8'h0E;
  localparam logic [7:0] ADDR_BUCKET_CFG = 8'h50;
  localparam logic [7:0] ADDR_SELECT = 8'h33;

  localparam int NETTYPE_BIT = 2;
  localparam int EDGE_SEL_BIT = 2;
  localparam int REF_LOST_BIT = 6;
  localparam int PHASE_LOST_EN_BIT = 6;
  localparam int MODE_PROGRAMMABLE_DIVIDE_BIT = 7;
  localparam int MODE_EIGHT_KHZ_LOCK_BIT = 6;

  localparam logic [7:0] FREQ_RESET_LOW = 8'h02;
  localparam logic [7:0] FREQ_RESET_HIGH = 8'h04;
  localparam logic [3:0] PRIO_RESET_ONE = 4'h2;
  localparam logic [3:0] PRIO_RESET_TWO = 4'h3;
  localparam logic [3:0] PRIO_RESET_THREE = 4'h4;
  localparam logic [3:0] PRIO_RESET_FOUR = 4'h5;
  localparam logic [3:0] CHAN_ONE = 4'h3;
  localparam logic [3:0] CHAN_TWO = 4'h4;
  localparam logic [3:0] CHAN_THREE = 4'h8;
  localparam logic [3:0] CHAN_FOUR = 4'h9;
  localparam logic [13:0] PROGRAMMABLE_DIVIDE_MIN = 14'h0001;
  localparam logic [13:0] PROGRAMMABLE_DIVIDE_MAX = 14'h30D3;

  localparam longint CLK_HZ = 20000000;
  localparam longint PERIOD_MS = 128;
  localparam longint PERIOD_CYCLES = CLK_HZ * PERIOD_MS / 1000;
  localparam logic [3:0] BUCKET_SIZE = 4'h8;
  localparam logic [3:0] BUCKET_SET = 4'h6;
  localparam logic [3:0] BUCKET_CLEAR = 4'h2;
  localparam logic [15:0] MISS_LIMIT_K8 = 16'h1388;
  localparam logic [15:0] MISS_LIMIT_K4 = 16'h2710;
  localparam logic [15:0] MISS_LIMIT_K2 = 16'h4E20;
  localparam logic [15:0] MISS_LIMIT_FAST = 16'h0008;

  typedef enum logic [3:0] {
    F_2K = 4'h0, F_8K = 4'h2, F_4K = 4'h1, F_T1E1 = 4'h3, F_6M48 = 4'h5,
    F_19M44 = 4'h4, F_25M92 = 4'h6, F_38M88 = 4'h7, F_51M84 = 4'h8,
    F_77M76 = 4'h9
  } spot_t;

  typedef struct packed {
    logic programmable_divide;
    logic eight_khz_lock;
    logic [1:0] bucket;
    logic [3:0] freq;
  } freq_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// file: tb/ref_source_model.sv
/*
 Four reference clock sources for the front end, plus out-of-band
 levels. Assumes run and oob_req change just after rising mclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
  parameter int HALF = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] run,
  input wire logic [3:0] oob_req,
  output logic [3:0] ref_clk,
  output logic [3:0] oob
);
  int cnt_q;

  // One shared rate, so every running source toggles at the same frequency.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      ref_clk <= '0;
    end else begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) begin
        ref_clk <= ref_clk ^ run;
      end
    end
  end

  assign oob = oob_req;
endmodule // ref_source_model
`default_nettype wire

// file: tb/test_input_ref_divider_monitor.sv
/*
 Self-checking bench for the reference front end. Assumes the source
 model drives mclk-synchronous reference levels.
*/
`timescale 1ns/1ps
`default_nettype none
module test_input_ref_divider_monitor
  import ref_front_pkg::*;
;
  localparam logic [7:0] CFG [4] = '{ADDR_FREQ_A, ADDR_FREQ_B,
    ADDR_FREQ_C, ADDR_FREQ_D};
  localparam logic [7:0] CHAN_EXP [4] = '{8'h03, 8'h04, 8'h08, 8'h09};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic net_pin = 1'b1;
  logic [3:0] run = '0;
  logic [3:0] oob_req = '0;
  logic [7:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  logic [7:0] rdata;
  logic [3:0] ref_clk, oob, div_out, avail, chan;
  logic hold, plost;
  logic [3:0] ref_prev = '0;
  logic [3:0] div_prev = '0;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int rise_at = 0;
  int lag = 0;
  int rise_cnt [4];
  int tog_cnt [4];

  always #25 mclk = ~mclk;

  ref_source_model #(.HALF(2)) src (.mclk(mclk), .rst(rst), .run(run),
    .oob_req(oob_req), .ref_clk(ref_clk), .oob(oob));

  ref_front uut (.mclk(mclk), .rst(rst), .net_select_pin(net_pin),
    .ref_in(ref_clk), .freq_out_of_band_in_unused_free(1'b0),
    .freq_out_of_band(oob), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .div_ref_out(div_out),
    .ref_available(avail), .holdover(hold), .phase_lost(plost),
    .selected_chan(chan));

  // Counts reference rises and divided toggles; lag is toggle phase.
  always @(posedge mclk) begin
    ref_prev <= ref_clk;
    div_prev <= div_out;
    cyc <= cyc + 1;
    if (ref_clk[0] && !ref_prev[0]) begin
      rise_at <= cyc;
    end
    if (div_out[0] !== div_prev[0]) begin
      lag <= (cyc - rise_at) % 4;
    end
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        rise_cnt[i] <= 0;
        tog_cnt[i] <= 0;
      end else begin
        if (ref_clk[i] && !ref_prev[i]) rise_cnt[i] <= rise_cnt[i] + 1;
        if (div_out[i] !== div_prev[i]) tog_cnt[i] <= tog_cnt[i] + 1;
      end
    end
  end

  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    total_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      fails++;
      $display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp,
                            input logic [7:0] mask);
    logic [7:0] d;
    reg_read(a, d);
    check_eq(d & mask, exp);
  endtask

  task automatic wait_hold(input logic exp, input int lim);
    for (int k = 0; k < lim && hold !== exp; k++) @(posedge mclk);
    #1 check_eq({7'h00, hold}, {7'h00, exp});
  endtask

  task automatic count_run(input int n);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic do_reset(input logic p);
    rst <= 1'b1;
    net_pin <= p;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d;
    int lag0;
    do_reset(1'b1);
    run <= 4'hF;
    check_eq({4'h0, chan}, 8'h03);
    expect_reg(ADDR_FREQ_A, 8'h02, 8'hFF);
    expect_reg(ADDR_FREQ_B, 8'h02, 8'hFF);
    expect_reg(ADDR_FREQ_C, 8'h04, 8'hFF);
    expect_reg(ADDR_FREQ_D, 8'h04, 8'hFF);
    expect_reg(ADDR_PRIORITY_AB, 8'h32, 8'hFF);
    expect_reg(ADDR_PRIORITY_CD, 8'h54, 8'hFF);
    expect_reg(ADDR_INPUT_SETUP, 8'h04, 8'h04);
    reg_write(ADDR_INPUT_SETUP, 8'h00);
    expect_reg(ADDR_INPUT_SETUP, 8'h00, 8'h04);
    expect_reg(8'h01, 8'h00, 8'hFF);
    reg_read(ADDR_FREQ_C, d);
    @(posedge mclk);
    #1 check_eq(rdata, 8'h00);
    reg_write(ADDR_DIV_LOW, 8'hF9);
    reg_write(ADDR_DIV_HIGH, 8'hFF);
    expect_reg(ADDR_DIV_LOW, 8'hF9, 8'hFF);
    expect_reg(ADDR_DIV_HIGH, 8'h3F, 8'h3F);
    for (int i = 0; i < 4; i++) reg_write(CFG[i], 8'h04);
    count_run(400);
    for (int i = 0; i < 4; i++) check_cnt(tog_cnt[i], rise_cnt[i]);
    reg_write(ADDR_DIV_LOW, 8'h03);
    reg_write(ADDR_DIV_HIGH, 8'h00);
    reg_write(CFG[1], 8'h80);
    reg_write(CFG[3], 8'hB0);
    count_run(800);
    check_cnt(tog_cnt[1], rise_cnt[1] / 4);
    check_cnt(tog_cnt[3], rise_cnt[3] / 4);
    check_cnt(tog_cnt[0], rise_cnt[0]);
    reg_write(ADDR_DIV_LOW, 8'h01);
    count_run(400);
    check_cnt(tog_cnt[1], rise_cnt[1] / 2);
    reg_write(ADDR_DIV_LOW, 8'hD3);
    reg_write(ADDR_DIV_HIGH, 8'h30);
    count_run(400);
    check_cnt(tog_cnt[1], 0);
    reg_write(CFG[0], 8'h42);
    count_run(400);
    check_cnt(tog_cnt[0], rise_cnt[0]);
    lag0 = lag;
    reg_write(ADDR_TEST_CTRL, 8'h04);
    repeat (40) @(posedge mclk);
    check_eq(8'((lag - lag0 + 4) % 4), 8'h02);
    reg_write(ADDR_TEST_CTRL, 8'h00);
    reg_write(CFG[0], 8'h04);
    repeat (20) @(posedge mclk);
    wait_hold(1'b0, 20);
    run <= 4'hE;
    wait_hold(1'b1, 30);
    expect_reg(ADDR_INT_STATUS, 8'h40, 8'h40);
    check_eq({7'h00, plost}, 8'h00);
    reg_write(ADDR_PHASE_SETUP, 8'h40);
    @(posedge mclk);
    #1 check_eq({7'h00, plost}, 8'h01);
    run <= 4'hF;
    wait_hold(1'b0, 50);
    expect_reg(ADDR_INT_STATUS, 8'h40, 8'h40);
    reg_write(ADDR_INT_STATUS, 8'h40);
    expect_reg(ADDR_INT_STATUS, 8'h00, 8'h40);
    check_eq({7'h00, avail[2]}, 8'h01);
    @(posedge mclk);
    oob_req <= 4'h4;
    for (int k = 0; k < 10 && avail[2] !== 1'b0; k++) @(posedge mclk);
    #1 check_eq({7'h00, avail[2]}, 8'h00);
    check_eq({7'h00, hold}, 8'h00);
    @(posedge mclk);
    oob_req <= 4'h0;
    for (int i = 1; i < 4; i++) begin
      reg_write(ADDR_SELECT, 8'(i));
      @(posedge mclk);
      #1 check_eq({4'h0, chan}, CHAN_EXP[i]);
    end
    reg_write(ADDR_INPUT_SETUP, 8'h04);
    reg_write(CFG[2], 8'h43);
    count_run(7800);
    check_cnt(tog_cnt[2], rise_cnt[2] / 193);
    do_reset(1'b0);
    expect_reg(ADDR_INPUT_SETUP, 8'h00, 8'h04);
    expect_reg(ADDR_FREQ_A, 8'h02, 8'hFF);
    report_and_stop();
  end
endmodule // test_input_ref_divider_monitor
`default_nettype wire
